//--- hdl/kbmbx_top.sv
// Keyboard host mailbox: output FIFO, host buffers, status, irq gating,
// port pins and power-down control.
// Assumes host and firmware strobes are synchronous to CLK_SYS and that
// the pad ring resolves the open-drain lines from the enables.
`timescale 1ns/10ps
`include "kbmbx_cfg.svh"

////////////////////////////////////////////////////////////////////////
// Output FIFO: firmware bytes queue here until the host buffer is free
////////////////////////////////////////////////////////////////////////
module kbmbx_fifo
   import kbmbx_pkg::*;
#(
   parameter int WIDTH = `KBMBX_FIFO_WIDTH,
   parameter int DEPTH = `KBMBX_FIFO_DEPTH
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             ce,
   input  wire logic             in_valid,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  in_ready,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH]; // Storage flops
   logic [AW-1:0]    wr_q;          // Write index
   logic [AW-1:0]    rd_q;          // Read index
   logic [AW:0]      cnt_q;         // Fill level
   logic [AW:0]      cnt_d;         // Next fill level
   logic             full_q;        // Registered full
   logic             empty_q;       // Registered empty
   logic             push;          // Accepted write
   logic             pop;           // Accepted read

   // Handshakes; flags are registered so ready never glitches
   assign push      = in_valid & ~full_q;
   assign pop       = out_ready & ~empty_q;
   assign in_ready  = ~full_q;
   assign out_valid = ~empty_q;
   assign out_data  = mem_q[rd_q];

   // Next fill level
   always_comb begin
      cnt_d = cnt_q;
      if (push && !pop) begin
         cnt_d = cnt_q + 1'b1;
      end else if (pop && !push) begin
         cnt_d = cnt_q - 1'b1;
      end
   end

   // Data storage, left without reset
   always_ff @(posedge clk) begin
      if (ce && push) begin
         mem_q[wr_q] <= in_data;
      end
   end

   // Indices and flags
   always_ff @(posedge clk) begin
      if (rst) begin
         wr_q    <= '0;
         rd_q    <= '0;
         cnt_q   <= '0;
         full_q  <= 1'b0;
         empty_q <= 1'b1;
      end else if (ce) begin
         if (push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= rd_q + 1'b1;
         end
         cnt_q   <= cnt_d;
         full_q  <= (cnt_d == (AW+1)'(DEPTH));
         empty_q <= (cnt_d == '0);
      end
   end

endmodule : kbmbx_fifo

////////////////////////////////////////////////////////////////////////
// Top: host mailbox and pin control
////////////////////////////////////////////////////////////////////////
module kbmbx_top
   import kbmbx_pkg::*;
(
   input  wire logic       CLK_SYS,
   input  wire logic       RST,
   input  wire logic       CE,
   input  wire logic       HOST_WR,
   input  wire logic       HOST_RD,
   input  wire logic       HOST_ADDR_BIT2,
   input  wire logic [7:0] HOST_WDATA,
   output logic      [7:0] HOST_RDATA,
   output logic            HOST_RVALID,
   input  wire logic       FW_DBB_WR,
   input  wire logic [7:0] FW_DBB_WDATA,
   output logic            FW_DBB_READY,
   input  wire logic       FW_DBB_RD,
   output logic      [7:0] FW_DBB_RDATA,
   input  wire logic       FW_STAT_WR,
   input  wire logic [7:0] FW_STAT_WDATA,
   output kbmbx_status_s   FW_STATUS,
   input  wire logic       FW_P1_WR,
   input  wire logic [7:0] FW_P1_WDATA,
   input  wire logic       FW_P1_OD,
   input  wire logic       FW_P2_WR,
   input  wire logic [7:0] FW_P2_WDATA,
   input  wire logic       FW_EN_FLAGS,
   input  wire logic       FW_HALT,
   input  wire logic       FW_STOP,
   input  wire logic       FW_IBF_IE,
   input  wire logic       FW_TMR_IE,
   input  wire logic       TIMER_OVF,
   output logic            CORE_IRQ,
   output logic            WAKE_CALL,
   output logic            WAKE_NEXT,
   output logic            ALU_CLK_EN,
   output logic            OSC_EN,
   output logic            KBD_IRQ_OUT,
   output logic            AUX_IRQ_OUT,
   output logic            GATE_A20,
   input  wire logic       KBD_CLK_LINE_I,
   output logic            KBD_CLK_LINE_O,
   output logic            KBD_CLK_LINE_OE,
   input  wire logic       KBD_DATA_LINE_I,
   output logic            KBD_DATA_LINE_O,
   output logic            KBD_DATA_LINE_OE,
   input  wire logic       AUX_CLK_LINE_I,
   output logic            AUX_CLK_LINE_O,
   output logic            AUX_CLK_LINE_OE,
   input  wire logic       AUX_DATA_LINE_I,
   output logic            AUX_DATA_LINE_O,
   output logic            AUX_DATA_LINE_OE,
   output logic            T_INPUT_ZERO,
   output logic            T_INPUT_ONE,
   output logic            PORT1_BIT0,
   output logic            PORT1_BIT1,
   output logic      [2:0] PORT1_PIN_O,
   output logic      [2:0] PORT1_PIN_OE
);
   localparam int PP_CYC = `KBMBX_PP_CYC;

   kbmbx_status_s st_q;        // Status byte
   kbmbx_pwr_e    pwr_q;       // Power state
   kbmbx_pin_s    pin_q [3];   // Port1 pin drive
   logic [7:0]    in_buf_q;    // Host-written byte
   logic [7:0]    out_buf_q;   // Host-readable byte
   logic [7:0]    p1_q;        // Port1 latch
   logic [7:0]    p2_q;        // Port2 latch
   logic [2:0]    pin_prev_q;  // Pin bits last cycle
   logic [3:0]    pp_cnt_q [3];// Active-high time left
   logic          en_flags_q;  // Flag gating on
   logic          kbd_irq_out_q;      // Keyboard irq flop
   logic          airq_q;      // Aux irq flop
   logic [3:0]    sync1_q;     // Line synchroniser, first stage
   logic [3:0]    sync2_q;     // Line synchroniser, second stage
   logic          fifo_valid;  // Byte waiting in FIFO
   logic [7:0]    fifo_data;   // Head of FIFO
   logic          fifo_pop;    // Move head to host buffer
   logic          host_dread;  // Host read of data byte
   logic [2:0]    pin_bits;    // Port1 bits on the pins

   // Pin drive for one quasi-bidirectional bit
   function automatic kbmbx_pin_s pin_drive(input logic bit_v, input logic od,
                                            input logic busy);
      kbmbx_pin_s p;
      p.o  = 1'b0;
      p.oe = 1'b0;
      if (od) begin
         p.oe = ~bit_v;
      end else if (!bit_v) begin
         p.oe = 1'b1;
      end else begin
         p.o  = busy;
         p.oe = busy;
      end
      return p;
   endfunction : pin_drive

   assign pin_bits   = {p1_q[`KBMBX_P1_PIN2], p1_q[`KBMBX_P1_PIN1],
                        p1_q[`KBMBX_P1_PIN0]};
   assign host_dread = HOST_RD & (HOST_ADDR_BIT2 == `KBMBX_SEL_DATA);
   // Host buffer takes the next queued byte only once it is empty
   assign fifo_pop   = fifo_valid & ~st_q.out_buf_full;

   /////////////////////////////////////////////////////////////////////
   // Firmware output path
   /////////////////////////////////////////////////////////////////////

   // Queue absorbs bursts; FW_DBB_READY stalls firmware when full
   kbmbx_fifo #(
      .WIDTH (`KBMBX_FIFO_WIDTH),
      .DEPTH (`KBMBX_FIFO_DEPTH)
   ) u_fifo (
      .clk       (CLK_SYS),
      .rst       (RST),
      .ce        (CE),
      .in_valid  (FW_DBB_WR),
      .in_data   (FW_DBB_WDATA),
      .in_ready  (FW_DBB_READY),
      .out_valid (fifo_valid),
      .out_ready (fifo_pop),
      .out_data  (fifo_data)
   );

   // Data buffers hold no reset value
   always_ff @(posedge CLK_SYS) begin
      if (CE) begin
         // R16: load host buffer
         if (fifo_pop) begin
            out_buf_q <= fifo_data;
         end
         if (HOST_WR) begin
            in_buf_q <= HOST_WDATA;
         end
      end
   end

   /////////////////////////////////////////////////////////////////////
   // Status byte
   /////////////////////////////////////////////////////////////////////

   // Hardware sets win over clears in the same cycle
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         // R21: status cleared
         st_q <= `KBMBX_STATUS_RST;
      end else if (CE) begin
         // R18: firmware owns user bits
         if (FW_STAT_WR) begin
            st_q.ud_hi <= FW_STAT_WDATA[7:4];
            st_q.ud_lo <= FW_STAT_WDATA[2];
         end
         // R1: command flag load
         // R23: address selects kind
         if (HOST_WR) begin
            st_q.cmd_data <= HOST_ADDR_BIT2;
         end
         // R20: host write sets
         // R17: firmware read clears
         if (HOST_WR) begin
            st_q.in_buf_full <= 1'b1;
         end else if (FW_DBB_RD) begin
            st_q.in_buf_full <= 1'b0;
         end
         // R16: output-full set
         // R19: host read clears
         if (fifo_pop) begin
            st_q.out_buf_full <= 1'b1;
         end else if (host_dread) begin
            st_q.out_buf_full <= 1'b0;
         end
      end
   end

   /////////////////////////////////////////////////////////////////////
   // Read ports
   /////////////////////////////////////////////////////////////////////

   // Host read answer, one cycle after the strobe
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         HOST_RDATA  <= 8'h00;
         HOST_RVALID <= 1'b0;
      end else if (CE) begin
         HOST_RVALID <= HOST_RD;
         // R23: status on command address
         if (HOST_RD) begin
            HOST_RDATA <= HOST_ADDR_BIT2 ? st_q : out_buf_q;
         end
      end
   end

   // Firmware read of the host byte
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         FW_DBB_RDATA <= 8'h00;
      end else if (CE) begin
         // R17: return host byte
         if (FW_DBB_RD) begin
            FW_DBB_RDATA <= in_buf_q;
         end
      end
   end

   assign FW_STATUS = st_q;

   /////////////////////////////////////////////////////////////////////
   // Port latches and host interrupts
   /////////////////////////////////////////////////////////////////////

   // Port latches; reset value makes all four lines pull low
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         p1_q <= `KBMBX_P1_RST;
         p2_q <= `KBMBX_P2_RST;
      end else if (CE) begin
         if (FW_P1_WR) begin
            p1_q <= FW_P1_WDATA;
         end
         if (FW_P2_WR) begin
            p2_q <= FW_P2_WDATA;
         end
      end
   end

   // Gating enable, only reset turns it off
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         en_flags_q <= 1'b0;
      end else if (CE) begin
         // R24: sticky gating enable
         if (FW_EN_FLAGS) begin
            en_flags_q <= 1'b1;
         end
      end
   end

   // Interrupt lines lag their sources by one cycle
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         // R4: keyboard irq cleared
         kbd_irq_out_q <= 1'b0;
         airq_q <= 1'b0;
      end else if (CE) begin
         if (en_flags_q) begin
            // R2: gated output-full
            kbd_irq_out_q <= p2_q[`KBMBX_P2_KBD_IRQ_OUT] & st_q.out_buf_full;
            // R5: inverted input-full
            airq_q <= p2_q[`KBMBX_P2_AIRQ] & ~st_q.in_buf_full;
         end else begin
            // R3: direct port bit
            kbd_irq_out_q <= p2_q[`KBMBX_P2_KBD_IRQ_OUT];
            // R6: direct port bit
            airq_q <= p2_q[`KBMBX_P2_AIRQ];
         end
      end
   end

   assign KBD_IRQ_OUT = kbd_irq_out_q;
   assign AUX_IRQ_OUT = airq_q;
   // R7: gate A20 bit
   assign GATE_A20    = p2_q[`KBMBX_P2_A20];

   /////////////////////////////////////////////////////////////////////
   // Keyboard and aux lines
   /////////////////////////////////////////////////////////////////////

   // R10: inverted keyboard lines
   // R11: inverted aux lines
   // Open-drain: a one in the latch pulls the line low
   assign KBD_CLK_LINE_OE  = p2_q[`KBMBX_P2_KBD_CLK_LINE];
   assign KBD_DATA_LINE_OE = p2_q[`KBMBX_P2_KBD_DATA_LINE];
   assign AUX_CLK_LINE_OE  = p2_q[`KBMBX_P2_ACLK];
   assign AUX_DATA_LINE_OE = p2_q[`KBMBX_P2_ADAT];
   assign KBD_CLK_LINE_O   = 1'b0;
   assign KBD_DATA_LINE_O  = 1'b0;
   assign AUX_CLK_LINE_O   = 1'b0;
   assign AUX_DATA_LINE_O  = 1'b0;

   // Two-stage synchroniser for the line read-back
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         sync1_q <= 4'h0;
         sync2_q <= 4'h0;
      end else if (CE) begin
         sync1_q <= {AUX_DATA_LINE_I, AUX_CLK_LINE_I,
                     KBD_DATA_LINE_I, KBD_CLK_LINE_I};
         sync2_q <= sync1_q;
      end
   end

   // R10: keyboard read-back
   assign T_INPUT_ZERO = sync2_q[0];
   assign PORT1_BIT0   = sync2_q[1];
   // R11: aux read-back
   assign T_INPUT_ONE  = sync2_q[2];
   assign PORT1_BIT1   = sync2_q[3];

   /////////////////////////////////////////////////////////////////////
   // Port1 quasi-bidirectional pins
   /////////////////////////////////////////////////////////////////////

   // A rising bit drives high for a short time, then the pull-up holds
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         pin_prev_q <= 3'h7;
         for (int i = 0; i < 3; i++) begin
            pp_cnt_q[i] <= 4'h0;
            pin_q[i]    <= '0;
         end
      end else if (CE) begin
         pin_prev_q <= pin_bits;
         for (int i = 0; i < 3; i++) begin
            // R8: timed high drive
            if (!FW_P1_OD && pin_bits[i] && !pin_prev_q[i]) begin
               pp_cnt_q[i] <= 4'(PP_CYC);
               pin_q[i]    <= pin_drive(1'b1, 1'b0, 1'b1);
            end else if (pp_cnt_q[i] != 4'h0 && !FW_P1_OD && pin_bits[i]) begin
               pp_cnt_q[i] <= pp_cnt_q[i] - 4'h1;
               pin_q[i]    <= pin_drive(1'b1, 1'b0, pp_cnt_q[i] != 4'h1);
            end else begin
               // R9: open-drain drive
               pp_cnt_q[i] <= 4'h0;
               pin_q[i]    <= pin_drive(pin_bits[i], FW_P1_OD, 1'b0);
            end
         end
      end
   end

   // Pin ports
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         PORT1_PIN_O[i]  = pin_q[i].o;
         PORT1_PIN_OE[i] = pin_q[i].oe;
      end
   end

   /////////////////////////////////////////////////////////////////////
   // Power-down and core interrupts
   /////////////////////////////////////////////////////////////////////

   // Reset restarts the core; a host byte resumes it
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         pwr_q      <= PWR_RUN;
         ALU_CLK_EN <= 1'b1;
         OSC_EN     <= 1'b1;
         WAKE_CALL  <= 1'b0;
         WAKE_NEXT  <= 1'b0;
      end else if (CE) begin
         WAKE_CALL <= 1'b0;
         WAKE_NEXT <= 1'b0;
         case (pwr_q)
            PWR_RUN: begin
               // R12: halt stops ALU
               if (FW_HALT) begin
                  pwr_q      <= PWR_SOFT;
                  ALU_CLK_EN <= 1'b0;
               // R14: stop kills oscillator
               end else if (FW_STOP) begin
                  pwr_q      <= PWR_HARD;
                  ALU_CLK_EN <= 1'b0;
                  OSC_EN     <= 1'b0;
               end
            end
            PWR_SOFT, PWR_HARD: begin
               // R13: wake by host byte
               if (HOST_WR) begin
                  pwr_q      <= PWR_RUN;
                  ALU_CLK_EN <= 1'b1;
                  OSC_EN     <= 1'b1;
                  WAKE_CALL  <= FW_IBF_IE;
                  WAKE_NEXT  <= ~FW_IBF_IE;
               end
            end
            default: begin
               pwr_q <= PWR_RUN;
            end
         endcase
      end
   end

   // Timer and input interrupts stay live while halted
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         CORE_IRQ <= 1'b0;
      end else if (CE) begin
         // R15: two core sources
         CORE_IRQ <= (FW_IBF_IE & st_q.in_buf_full) | (FW_TMR_IE & TIMER_OVF);
      end
   end

   /////////////////////////////////////////////////////////////////////
   // Checks
   /////////////////////////////////////////////////////////////////////

   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RST);

   sequence s_halt_enter;
      CE && pwr_q == PWR_RUN && FW_HALT;
   endsequence

   sequence s_host_wake;
      CE && pwr_q != PWR_RUN && HOST_WR && FW_IBF_IE;
   endsequence

   property p_cd_load;
      (CE && HOST_WR) |=> st_q.cmd_data == $past(HOST_ADDR_BIT2);
   endproperty
   a_cd_load: assert property (p_cd_load) else $error("cmd flag wrong"); // R1

   property p_kbd_irq_out_gated;
      (CE && en_flags_q) |=> KBD_IRQ_OUT == $past(p2_q[4] & st_q.out_buf_full);
   endproperty
   a_kbd_irq_out_gated: assert property (p_kbd_irq_out_gated) else $error("kbd_irq_out gate"); // R2

   property p_kbd_irq_out_direct;
      (CE && !en_flags_q) |=> KBD_IRQ_OUT == $past(p2_q[4]);
   endproperty
   a_kbd_irq_out_direct: assert property (p_kbd_irq_out_direct) else $error("kbd_irq_out direct"); // R3

   property p_kbd_irq_out_rst;
      disable iff (1'b0) RST |=> !KBD_IRQ_OUT && st_q == 8'h00;
   endproperty
   a_kbd_irq_out_rst: assert property (p_kbd_irq_out_rst) else $error("reset state"); // R4

   property p_airq_gated;
      (CE && en_flags_q) |=> AUX_IRQ_OUT == $past(p2_q[5] & ~st_q.in_buf_full);
   endproperty
   a_airq_gated: assert property (p_airq_gated) else $error("airq gate"); // R5

   property p_od_float;
      (CE && FW_P1_OD && pin_bits[0]) |=> !PORT1_PIN_OE[0];
   endproperty
   a_od_float: assert property (p_od_float) else $error("od drove"); // R9

   property p_pp_release;
      (PORT1_PIN_OE[0] && PORT1_PIN_O[0]) |-> pp_cnt_q[0] != 4'h0;
   endproperty
   a_pp_release: assert property (p_pp_release) else $error("pp held"); // R8

   property p_halt;
      s_halt_enter |=> !ALU_CLK_EN && pwr_q == PWR_SOFT;
   endproperty
   a_halt: assert property (p_halt) else $error("halt missed"); // R12

   property p_wake;
      s_host_wake |=> WAKE_CALL && !WAKE_NEXT && ALU_CLK_EN;
   endproperty
   a_wake: assert property (p_wake) else $error("wake call"); // R13

   property p_obf_clr;
      (CE && host_dread && !fifo_pop) |=> !st_q.out_buf_full;
   endproperty
   a_obf_clr: assert property (p_obf_clr) else $error("obf clear"); // R19

   property p_ibf;
      (CE && HOST_WR) |=> st_q.in_buf_full;
   endproperty
   a_ibf: assert property (p_ibf) else $error("ibf set"); // R20

   property p_sticky;
      en_flags_q |=> en_flags_q;
   endproperty
   a_sticky: assert property (p_sticky) else $error("gating lost"); // R24

endmodule : kbmbx_top

//--- hdl/kbmbx_cfg.svh
// Constants of the keyboard host mailbox: timing, reset values, pin bits.
// Assumes a 20 MHz system clock and an 8-bit controller core beside it.
// Functional notes
// R1: Host write loads command flag from address bit
// R2: Gated keyboard irq follows output-full when enabled
// R3: Ungated keyboard irq follows port2 bit4
// R4: Keyboard irq is zero after reset
// R5: Gated aux irq is inverse of input-full
// R6: Ungated aux irq follows port2 bit5
// R7: Port2 bit1 drives gate A20 output
// R8: Push-pull pins drive high briefly, then release
// R9: Open-drain pins drive low or float only
// R10: Keyboard clock/data inverted from port2, read back
// R11: Aux clock/data inverted from port2, read back
// R12: Halt stops ALU until reset or host write
// R13: Wake calls interrupt if enabled, else continues
// R14: Stop disables oscillator, same wake events
// R15: Core interrupts are input-full and timer overflow
// R16: Firmware buffer write loads output, sets output-full
// R17: Firmware buffer read returns byte, clears input-full
// R18: Status layout: output-full, input-full, command flag
// R19: Host data read clears output-full
// R20: Every host write sets input-full
// R21: Reset clears status and pulls lines low
// R22: Reset held at least 24 reference periods
// R23: Data address clears command flag, command sets
// R24: Flag gating stays on until next reset
`ifndef KBMBX_CFG_SVH
`define KBMBX_CFG_SVH

// Host address bit two selects data or command/status
`define KBMBX_SEL_DATA     1'b0
`define KBMBX_SEL_CMD      1'b1

// Reset values
`define KBMBX_STATUS_RST   8'h00
`define KBMBX_P1_RST       8'hFF
`define KBMBX_P2_RST       8'hCC

// Port2 bit positions
`define KBMBX_P2_A20       1
`define KBMBX_P2_ADAT      2
`define KBMBX_P2_ACLK      3
`define KBMBX_P2_KBD_IRQ_OUT      4
`define KBMBX_P2_AIRQ      5
`define KBMBX_P2_KBD_CLK_LINE      6
`define KBMBX_P2_KBD_DATA_LINE      7

// Port1 bit positions of the three quasi-bidirectional pins
`define KBMBX_P1_PIN0      2
`define KBMBX_P1_PIN1      6
`define KBMBX_P1_PIN2      7

// Timing
`define KBMBX_CLK_MHZ      20
`define KBMBX_PP_HIGH_NS   500
`define KBMBX_PP_CYC       ((`KBMBX_PP_HIGH_NS * `KBMBX_CLK_MHZ) / 1000)
`define KBMBX_RST_MIN_REF  24

// Output FIFO shape
`define KBMBX_FIFO_WIDTH   8
`define KBMBX_FIFO_DEPTH   32

`endif

//--- hdl/kbmbx_pkg.sv
// Types shared by the keyboard host mailbox.
// Assumes kbmbx_cfg.svh for the numeric constants.
package kbmbx_pkg;

   // Status byte as seen by host and firmware
   typedef struct packed {
      logic [3:0] ud_hi;        // User bits 7..4
      logic       cmd_data;     // One marks a command byte
      logic       ud_lo;        // User bit 2
      logic       in_buf_full;  // Host byte waiting
      logic       out_buf_full; // Firmware byte waiting
   } kbmbx_status_s;

   // One driven pin: level and enable
   typedef struct packed {
      logic o;                  // Driven level
      logic oe;                 // High while driving
   } kbmbx_pin_s;

   // Power state of the controller core
   typedef enum logic [1:0] {
      PWR_RUN,
      PWR_SOFT,
      PWR_HARD
   } kbmbx_pwr_e;

endpackage : kbmbx_pkg

//--- verification/kbmbx_host.sv
// Host bus model: single-byte writes and reads at the mailbox.
// Assumes strobes sampled on CLK_SYS rising edges.
`timescale 1ns/10ps
module kbmbx_host (
   input  wire logic       clk,
   output logic            wr,
   output logic            rd,
   output logic            a2,
   output logic [7:0]      wd
);
   initial begin
      wr = 1'b0;
      rd = 1'b0;
      a2 = 1'b0;
      wd = 8'h00;
   end
   task automatic acc(input logic w, input logic a, input logic [7:0] d);
      wr = w;
      rd = ~w;
      a2 = a;
      wd = d;
      @(posedge clk);
      #1;
      wr = 1'b0;
      rd = 1'b0;
      wd = ~d; // Released bus shows no stale byte
   endtask : acc
endmodule : kbmbx_host

//--- verification/kbmbx_top_tb.sv
// Bench of the keyboard host mailbox; host reads checked off a queue.
// Assumes pull-ups on the four open-drain lines.
`timescale 1ns/10ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin errors++; $display("[ERR] %0t %h %h", $time, a, b); end end
module kbmbx_top_tb;
   import kbmbx_pkg::*;
   logic CLK_SYS = 1'b0, RST = 1'b1, CE = 1'b1, FW_DBB_WR = 1'b0, FW_DBB_RD = 1'b0;
   logic FW_P1_WR = 1'b0, FW_P1_OD = 1'b0, FW_P2_WR = 1'b0, FW_EN_FLAGS = 1'b0;
   logic FW_HALT = 1'b0, FW_STOP = 1'b0, FW_IBF_IE = 1'b0, FW_TMR_IE = 1'b0;
   logic TIMER_OVF = 1'b0, FW_STAT_WR = 1'b0, HOST_WR, HOST_RD, HOST_ADDR_BIT2;
   logic [7:0] HOST_WDATA, FW_DBB_WDATA = 8'h00, FW_STAT_WDATA = 8'h00, e, p;
   logic [7:0] FW_P1_WDATA = 8'hFF, FW_P2_WDATA = 8'h00, HOST_RDATA, FW_DBB_RDATA;
   logic HOST_RVALID, FW_DBB_READY, CORE_IRQ, WAKE_CALL, WAKE_NEXT, ALU_CLK_EN, OSC_EN;
   logic KBD_IRQ_OUT, AUX_IRQ_OUT, GATE_A20, KBD_CLK_LINE_O, KBD_CLK_LINE_OE;
   logic KBD_DATA_LINE_O, KBD_DATA_LINE_OE, AUX_CLK_LINE_O, AUX_CLK_LINE_OE;
   logic AUX_DATA_LINE_O, AUX_DATA_LINE_OE, T_INPUT_ZERO, T_INPUT_ONE, PORT1_BIT0;
   logic PORT1_BIT1;
   logic [2:0] PORT1_PIN_O, PORT1_PIN_OE;
   kbmbx_status_s FW_STATUS;
   wire KBD_CLK_LINE_I = ~KBD_CLK_LINE_OE;
   wire KBD_DATA_LINE_I = ~KBD_DATA_LINE_OE;
   wire AUX_CLK_LINE_I = ~AUX_CLK_LINE_OE;
   wire AUX_DATA_LINE_I = ~AUX_DATA_LINE_OE;
   logic [7:0] exp_q[$];
   int errors = 0, total_checks = 0, cycles = 0, seed = 32'h1342, n, i;
   kbmbx_top dut (.*);
   kbmbx_host host (.clk(CLK_SYS), .wr(HOST_WR), .rd(HOST_RD), .a2(HOST_ADDR_BIT2),
      .wd(HOST_WDATA));
   always #25 CLK_SYS = ~CLK_SYS;
   ////////////////////////////////////////////////////////////////////////
   task automatic close_out();
      if (errors == 0 && total_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : close_out
   task automatic cyc(input int k);
      repeat (k) @(posedge CLK_SYS);
      #1;
   endtask : cyc
   task automatic pulse(ref logic s);
      s = 1'b1;
      cyc(1);
      s = 1'b0;
   endtask : pulse
   // Bounded wait for a byte in the output buffer
   task automatic hold_obf();
      int k;
      k = 0;
      while (FW_STATUS.out_buf_full !== 1'b1 && k < 20) begin
         cyc(1);
         k++;
      end
   endtask : hold_obf
   // Hang guard
   always @(posedge CLK_SYS) begin
      cycles++;
      if (cycles == 3000) begin
         errors++;
         close_out();
      end
   end
   // Each host read answer against the oldest note
   always @(negedge CLK_SYS) begin
      if (HOST_RVALID === 1'b1) begin
         e = exp_q.pop_front();
         `CHK(HOST_RDATA, e)
      end
   end
   ////////////////////////////////////////////////////////////////////////
   initial begin
      cyc(4);
      RST = 1'b0;
      `CHK(FW_STATUS, 8'h00)
      `CHK({KBD_CLK_LINE_OE, KBD_DATA_LINE_OE, AUX_CLK_LINE_OE, AUX_DATA_LINE_OE}, 4'hF)
      `CHK(KBD_IRQ_OUT, 1'b0)
      // Data then command byte, status read, firmware read
      for (i = 0; i < 2; i++) begin
         p = 8'($random(seed));
         host.acc(1'b1, i[0], p);
         cyc(1);
         exp_q.push_back({4'h0, i[0], 3'b010});
         host.acc(1'b0, 1'b1, 8'h00);
         pulse(FW_DBB_RD);
         cyc(2);
         `CHK(FW_DBB_RDATA, p)
         `CHK(FW_STATUS.in_buf_full, 1'b0)
      end
      // Ungated irqs, gate A20 and line drive from port2
      for (i = 0; i < 8; i++) begin
         p = 8'($random(seed));
         FW_P2_WDATA = p;
         pulse(FW_P2_WR);
         cyc(4);
         `CHK({KBD_IRQ_OUT, AUX_IRQ_OUT, GATE_A20}, {p[4], p[5], p[1]})
         `CHK({T_INPUT_ZERO, PORT1_BIT0, T_INPUT_ONE, PORT1_BIT1}, ~{p[6], p[7], p[3], p[2]})
      end
      // Fill the FIFO until refused, then drain in order
      n = 0;
      while (FW_DBB_READY === 1'b1 && n < 40) begin
         FW_DBB_WDATA = 8'($random(seed));
         exp_q.push_back(FW_DBB_WDATA);
         FW_DBB_WR = 1'b1;
         cyc(1);
         n++;
      end
      FW_DBB_WR = 1'b0;
      `CHK(n, 33)
      for (i = 0; i < n; i++) begin
         hold_obf();
         host.acc(1'b0, 1'b0, 8'h00);
         cyc(1);
      end
      cyc(2);
      `CHK(FW_STATUS.out_buf_full, 1'b0)
      // Flag gating
      pulse(FW_EN_FLAGS);
      FW_P2_WDATA = 8'h30;
      pulse(FW_P2_WR);
      host.acc(1'b1, 1'b0, 8'h5A);
      cyc(3);
      `CHK(AUX_IRQ_OUT, 1'b0)
      FW_DBB_WDATA = 8'hC3;
      exp_q.push_back(8'hC3);
      pulse(FW_DBB_WR);
      cyc(4);
      `CHK(KBD_IRQ_OUT, 1'b1)
      host.acc(1'b0, 1'b0, 8'h00);
      cyc(3);
      `CHK(KBD_IRQ_OUT, 1'b0)
      pulse(FW_DBB_RD);
      cyc(3);
      `CHK(AUX_IRQ_OUT, 1'b1)
      // Power-down and wake by host write
      FW_IBF_IE = 1'b1;
      pulse(FW_STOP);
      cyc(1);
      `CHK({ALU_CLK_EN, OSC_EN}, 2'b00)
      host.acc(1'b1, 1'b1, 8'h11);
      `CHK({WAKE_CALL, WAKE_NEXT}, 2'b10)
      cyc(2);
      `CHK({ALU_CLK_EN, OSC_EN}, 2'b11)
      `CHK(CORE_IRQ, 1'b1)
      FW_IBF_IE = 1'b0;
      FW_TMR_IE = 1'b1;
      TIMER_OVF = 1'b1;
      cyc(1);
      `CHK(CORE_IRQ, 1'b1)
      TIMER_OVF = 1'b0;
      cyc(1);
      `CHK(CORE_IRQ, 1'b0)
      // Port1 push-pull high then release, then open drain
      FW_P1_WDATA = 8'h00;
      pulse(FW_P1_WR);
      cyc(1);
      FW_P1_WDATA = 8'hFF;
      pulse(FW_P1_WR);
      cyc(1);
      `CHK({PORT1_PIN_O, PORT1_PIN_OE}, 6'h3F)
      cyc(12);
      `CHK(PORT1_PIN_OE, 3'h0)
      FW_P1_OD = 1'b1;
      FW_P1_WDATA = 8'h04;
      pulse(FW_P1_WR);
      cyc(2);
      `CHK(PORT1_PIN_OE, 3'h6)
      // Halt and wake, frozen write, halt again and leave by reset
      pulse(FW_HALT);
      `CHK(ALU_CLK_EN, 1'b0)
      host.acc(1'b1, 1'b0, 8'h22);
      `CHK({WAKE_CALL, WAKE_NEXT, ALU_CLK_EN}, 3'b011)
      FW_STAT_WDATA = 8'hFF;
      pulse(FW_STAT_WR);
      CE = 1'b0;
      host.acc(1'b1, 1'b1, 8'h33);
      CE = 1'b1;
      `CHK(FW_STATUS, 8'hF6)
      pulse(FW_HALT);
      RST = 1'b1;
      cyc(48); // well past 24 reference periods
      RST = 1'b0;
      `CHK({ALU_CLK_EN, OSC_EN, FW_STATUS, KBD_IRQ_OUT}, 11'h600)
      `CHK({KBD_CLK_LINE_O, KBD_DATA_LINE_O, AUX_CLK_LINE_O, AUX_DATA_LINE_O}, 4'h0)
      close_out();
   end
endmodule : kbmbx_top_tb
